// ==== dv/sfs_front_end_tb.sv ====
`timescale 1ns/100ps
module sfs_front_end_tb
    import sfs_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, sck, cs_n, si, flip_q = 1'b0;
    logic [3:0] lines, dq, oe_n;
    sfs_cmd_t cmd, last_cmd;
    sfs_prog_t prog;
    sfs_prog_t prog_q[$];
    logic rd_valid = 1'b0, rd_ready, under, took_q = 1'b0, feed_en = 1'b0;
    logic [7:0] feed_q = 8'h00;
    int num_errors = 0, check_count = 0, cmd_cnt = 0, und_cnt = 0;
    // ----------------------------------------
    // clock, wires, array side
    // ----------------------------------------
    initial
    begin
        forever #20 clk = ~clk;
    end
    // no pull on serial out: changing pattern when floating
    always @(negedge clk) flip_q <= ~flip_q;
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            lines[i] = !oe_n[i] ? dq[i] : (i > 1) ? 1'b1 : (i == 0) ? si : flip_q;
    end
    // array feeder, one byte per accepted push
    always @(posedge clk) took_q <= rd_valid && rd_ready;
    always @(negedge clk)
    begin
        if (took_q)
            feed_q <= feed_q + 8'h01;
        rd_valid <= feed_en;
    end
    // capture of commands, program bytes and underruns
    always @(posedge clk)
    begin
        if (cmd.valid === 1'b1)
        begin
            last_cmd <= cmd;
            cmd_cnt <= cmd_cnt + 1;
        end
        if (prog.valid === 1'b1)
            prog_q.push_back(prog);
        if (under === 1'b1)
            und_cnt <= und_cnt + 1;
    end
    sfs_host sfs_host_i (.i_sys_clk(clk), .o_sck(sck), .o_cs_n(cs_n), .o_si(si),
        .i_lines(lines));
    sfs_front_end sfs_front_end_i (.i_sys_clk(clk), .i_rst(rst), .i_sck(sck),
        .i_cs_n(cs_n), .i_quad_data_lines(lines), .o_quad_data_lines(dq),
        .o_quad_data_lines_oe_n(oe_n), .o_cmd(cmd), .o_prog(prog),
        .i_rd_valid(rd_valid), .i_rd_data(feed_q), .o_rd_ready(rd_ready),
        .o_rd_underrun(under));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic put3(input logic [23:0] a);
        sfs_host_i.put(a[23:16]);
        sfs_host_i.put(a[15:8]);
        sfs_host_i.put(a[7:0]);
    endtask
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // every erase size, upper address bits set
    task automatic t_erase();
        logic [7:0] ops [5] = '{SFS_OP_ERASE_4K, SFS_OP_ERASE_32K, SFS_OP_ERASE_64K,
            SFS_OP_ERASE_CHIP_A, SFS_OP_ERASE_CHIP_B};
        logic [18:0] msk [5] = '{SFS_MASK_4K, SFS_MASK_32K, SFS_MASK_64K, 19'h0, 19'h0};
        int n0;
        n0 = cmd_cnt;
        for (int k = 0; k < 5; k++)
        begin
            sfs_host_i.sel();
            sfs_host_i.put(ops[k]);
            check(32'(oe_n), 32'h0000_000D);
            if (k < 3)
                put3(24'hFD_B456);
            sfs_host_i.desel();
            check(32'(cmd_cnt), 32'(n0 + k + 1));
            check(32'(last_cmd.kind), 32'(k < 3 ? k + 2 : 5));
            check(32'(last_cmd.addr), 32'(19'h5_B456 & msk[k]));
            check(32'(oe_n), 32'h0000_000F);
        end
        $display("test erase done");
    endtask
    // page program running past the page end wraps
    task automatic t_prog();
        prog_q.delete();
        sfs_host_i.sel();
        sfs_host_i.put(SFS_OP_PROGRAM);
        put3(24'hE1_23FE);
        for (int k = 0; k < 3; k++)
            sfs_host_i.put(8'h11 * 8'(k + 1));
        sfs_host_i.desel();
        check(32'(last_cmd.kind), 32'(SFS_K_PROGRAM));
        check(32'(last_cmd.addr), 32'h0001_23FE);
        check(32'(prog_q.size()), 32'h0000_0003);
        for (int k = 0; k < 3; k++)
        begin
            check(32'(prog_q[k].addr), 32'(19'h1_2300 | 19'((8'hFE + k) % 256)));
            check(32'(prog_q[k].data), 32'(8'h11 * 8'(k + 1)));
        end
        $display("test program done");
    endtask
    // unknown opcode then an early release
    task automatic t_refuse();
        int n0;
        n0 = cmd_cnt;
        sfs_host_i.sel();
        sfs_host_i.put(8'h9F);
        sfs_host_i.put(SFS_OP_ERASE_4K);
        put3(24'h01_2345);
        sfs_host_i.desel();
        check(32'(cmd_cnt), 32'(n0));
        sfs_host_i.sel();
        sfs_host_i.put(SFS_OP_ERASE_4K);
        sfs_host_i.put(8'h01);
        sfs_host_i.put(8'h23);
        sfs_host_i.desel();
        check(32'(cmd_cnt), 32'(n0));
        $display("test refuse done");
    endtask
    // read: buffer filled until refused, drained, then underrun
    task automatic t_read(input logic [7:0] op, input int w, input logic [3:0] oe);
        logic [7:0] b;
        int u0;
        feed_en = 1'b0;
        sfs_host_i.sel();
        sfs_host_i.put(op);
        put3(24'h12_3456);
        check(32'(last_cmd.kind), 32'(SFS_K_READ));
        check(32'(last_cmd.addr), 32'h0002_3456);
        feed_q = 8'hA0;
        feed_en = 1'b1;
        sfs_host_i.put(8'hFF);
        feed_en = 1'b0;
        check(32'(rd_ready), 32'h0000_0000);
        u0 = und_cnt;
        for (int k = 0; k < 5; k++)
        begin
            sfs_host_i.get(w, b);
            check(32'(oe_n), 32'(oe));
            check(32'(b), 32'(k < 4 ? 8'hA0 + 8'(k) : 8'h00));
        end
        check(32'(und_cnt > u0), 32'h0000_0001);
        sfs_host_i.desel();
        check(32'(oe_n), 32'h0000_000F);
        $display("test read %h done", op);
    endtask
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        check(32'(oe_n), 32'h0000_000F);
        t_erase();
        t_prog();
        t_refuse();
        t_read(SFS_OP_READ_FAST, 1, 4'hD);
        t_read(SFS_OP_READ_DUAL, 2, 4'hC);
        sfs_host_i.mode(1'b1);
        t_read(SFS_OP_READ_QUAD, 4, 4'h0);
        complete_run();
    end
    initial
    begin
        repeat (40000) @(posedge clk);
        num_errors++;
        complete_run();
    end
endmodule // sfs_front_end_tb

// ==== dv/sfs_host.sv ====
`timescale 1ns/100ps
// ----------------------------------------
// spi host model, clock mode 0 or 3
// ----------------------------------------
module sfs_host (
    // pacing clock
    input wire logic i_sys_clk,
    // link pins
    output logic o_sck,
    output logic o_cs_n,
    output logic o_si,
    input wire logic [3:0] i_lines
);
    logic cpol = 1'b0;  // idle clock level, high for mode 3
    // idle: deselected, clock low
    initial
    begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
    end
    // half a link clock period, 160 ns
    task automatic half();
        repeat (4) @(negedge i_sys_clk);
    endtask
    // switch idle clock level while deselected
    task automatic mode(input logic m);
        cpol = m;
        o_sck = m;
        half();
    endtask
    // select opens an operation, mode 3 clock falls first
    task automatic sel();
        o_cs_n = 1'b0;
        half();
        o_sck = 1'b0;
    endtask
    // release ends it, clock back to its idle level
    task automatic desel();
        half();
        o_cs_n = 1'b1;
        half();
        o_sck = cpol;
        half();
    endtask
    // byte out msb first, changed while clock low
    task automatic put(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
        begin
            o_si = b[i];
            half();
            o_sck = 1'b1;
            half();
            o_sck = 1'b0;
        end
    endtask
    // byte in over w lanes, taken at the rise
    task automatic get(input int w, output logic [7:0] b);
        for (int i = 0; i < 8 / w; i++)
        begin
            half();
            o_sck = 1'b1;
            b = (w == 1) ? {b[6:0], i_lines[1]} :
                (w == 2) ? {b[5:0], i_lines[1:0]} : {b[3:0], i_lines};
            half();
            o_sck = 1'b0;
        end
    endtask
endmodule // sfs_host

// ==== hw/sfs_front_end.sv ====
`timescale 1ns/100ps

// ----------------------------------------
// read data buffer
// ----------------------------------------
module sfs_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_flush,
    // filling side
    input wire logic i_in_valid,
    input wire logic [W-1:0] i_in_data,
    output logic o_in_ready,
    // draining side
    output logic o_out_valid,
    output logic [W-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_depth_check
        $error("fifo depth must be a power of two, at least 2");
    end

    // whole buffer state
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
        logic in_rdy;
    } sfs_fifo_st_t;

    sfs_fifo_st_t s_q, s_d;
    logic push, pop;

    assign o_in_ready = s_q.in_rdy;
    assign o_out_valid = (s_q.cnt != '0);
    assign o_out_data = s_q.mem[s_q.rd];

    // pointer and count update
    always_comb
    begin
        s_d = s_q;
        push = i_in_valid && s_q.in_rdy;
        pop = i_out_ready && (s_q.cnt != '0);
        if (push)
        begin
            s_d.mem[s_q.wr] = i_in_data;
            s_d.wr = s_q.wr + 1'b1;
        end
        if (pop)
        begin
            s_d.rd = s_q.rd + 1'b1;
        end
        s_d.cnt = s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        // flush drops stale bytes of a previous read
        if (i_flush)
        begin
            s_d.wr = '0;
            s_d.rd = '0;
            s_d.cnt = '0;
        end
        s_d.in_rdy = (s_d.cnt != DEPTH[AW:0]);
    end

    // state register
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end
endmodule // sfs_fifo

// ----------------------------------------
// serial flash link front end
// ----------------------------------------
module sfs_front_end
    import sfs_pkg::*;
#(
    parameter int RD_DEPTH = SFS_FIFO_DEPTH
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // serial link pins
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic [3:0] i_quad_data_lines,
    output logic [3:0] o_quad_data_lines,
    output logic [3:0] o_quad_data_lines_oe_n,
    // commands and program data to the array
    output sfs_cmd_t o_cmd,
    output sfs_prog_t o_prog,
    // read data from the array
    input wire logic i_rd_valid,
    input wire logic [7:0] i_rd_data,
    output logic o_rd_ready,
    output logic o_rd_underrun
);
    if (RD_DEPTH < 2)
    begin : g_depth_check
        $error("read buffer depth must be at least 2");
    end

    // whole link state
    typedef struct packed {
        logic sck_s1, sck_s2, sck_s3;     // clock synchroniser and edge tap
        logic cs_s1, cs_s2;               // select synchroniser
        logic [3:0] qd_s1, qd_s2;         // data line synchroniser
        sfs_phase_t phase;
        logic [4:0] cnt;                  // bits taken in the field
        logic [23:0] shin;                // incoming shift register
        sfs_kind_t kind;
        sfs_lane_t lanes;
        logic dummy;                      // read needs a dummy byte
        logic [18:0] page;                // program page base
        logic [7:0] off;                  // program byte offset
        logic [7:0] osr;                  // outgoing shift register
        logic [3:0] oleft;                // bits left in osr
        logic [3:0] qd_out;
        logic [3:0] qd_oe_n;
        sfs_cmd_t cmd;
        sfs_prog_t prog;
        logic underrun;
    } sfs_st_t;

    sfs_st_t s_q, s_d;
    logic rise, fall, si;             // link events of this cycle
    logic [7:0] op_in;                // completed opcode
    logic [23:0] a_in;                // completed address
    logic [7:0] ob;                   // byte being shifted out
    logic [3:0] step;                 // bits per falling edge
    logic flush, pop;
    logic fifo_valid;
    logic [7:0] fifo_data;
    sfs_phase_t ph;

    // ----------------------------------------
    // read data buffer
    // ----------------------------------------
    sfs_fifo #(.W(SFS_BYTE_W), .DEPTH(RD_DEPTH)) sfs_fifo_i (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_flush(flush),
        .i_in_valid(i_rd_valid),
        .i_in_data(i_rd_data),
        .o_in_ready(o_rd_ready),
        .o_out_valid(fifo_valid),
        .o_out_data(fifo_data),
        .i_out_ready(pop)
    );

    // ----------------------------------------
    // link sequencing
    // ----------------------------------------
    // next state of sampling, decode and shifting
    always_comb
    begin
        s_d = s_q;
        flush = 1'b0;
        pop = 1'b0;
        ob = s_q.osr;
        step = 4'h1;
        si = s_q.qd_s2[0];
        op_in = {s_q.shin[6:0], si};   // msb first
        a_in = {s_q.shin[22:0], si};
        // edges found on the synchronised clock, either idle level
        rise = s_q.sck_s2 && !s_q.sck_s3;
        fall = !s_q.sck_s2 && s_q.sck_s3;
        ph = (s_q.phase == SFS_IDLE) ? SFS_OPCODE : s_q.phase;
        s_d.sck_s1 = i_sck;
        s_d.sck_s2 = s_q.sck_s1;
        s_d.sck_s3 = s_q.sck_s2;
        s_d.cs_s1 = i_cs_n;
        s_d.cs_s2 = s_q.cs_s1;
        s_d.qd_s1 = i_quad_data_lines;
        s_d.qd_s2 = s_q.qd_s1;
        s_d.cmd.valid = 1'b0;
        s_d.prog.valid = 1'b0;
        s_d.underrun = 1'b0;
        if (s_q.cs_s2)
        begin
            // release ends or drops the operation
            s_d.phase = SFS_IDLE;
            s_d.cnt = '0;
            s_d.lanes = SFS_LANE_1;
            s_d.oleft = '0;
        end
        else
        begin
            s_d.phase = ph;
            unique case (ph)
                SFS_OPCODE:
                begin
                    if (rise)
                    begin
                        // opcode is the first byte after select
                        s_d.shin = a_in;
                        s_d.cnt = s_q.cnt + 5'h01;
                        if (s_q.cnt == SFS_BYTE_LAST)
                        begin
                            s_d.cnt = '0;
                            s_d.phase = SFS_ADDR;
                            s_d.dummy = 1'b0;
                            s_d.lanes = SFS_LANE_1;
                            unique case (op_in)
                                SFS_OP_READ: s_d.kind = SFS_K_READ;
                                SFS_OP_READ_FAST:
                                begin
                                    s_d.kind = SFS_K_READ;
                                    s_d.dummy = 1'b1;
                                end
                                SFS_OP_READ_DUAL:
                                begin
                                    s_d.kind = SFS_K_READ;
                                    s_d.dummy = 1'b1;
                                    s_d.lanes = SFS_LANE_2;
                                end
                                SFS_OP_READ_QUAD:
                                begin
                                    s_d.kind = SFS_K_READ;
                                    s_d.dummy = 1'b1;
                                    s_d.lanes = SFS_LANE_4;
                                end
                                // erase granularity chosen by opcode
                                SFS_OP_ERASE_4K: s_d.kind = SFS_K_ERASE_4K;
                                SFS_OP_ERASE_32K: s_d.kind = SFS_K_ERASE_32K;
                                SFS_OP_ERASE_64K: s_d.kind = SFS_K_ERASE_64K;
                                SFS_OP_PROGRAM: s_d.kind = SFS_K_PROGRAM;
                                SFS_OP_ERASE_CHIP_A, SFS_OP_ERASE_CHIP_B:
                                begin
                                    // whole chip needs no address
                                    s_d.kind = SFS_K_ERASE_CHIP;
                                    s_d.phase = SFS_IGNORE;
                                    s_d.cmd = '{1'b1, SFS_K_ERASE_CHIP, '0};
                                end
                                default:
                                begin
                                    // unknown opcode: deaf until reselect
                                    s_d.kind = SFS_K_NONE;
                                    s_d.phase = SFS_IGNORE;
                                end
                            endcase
                        end
                    end
                end
                SFS_ADDR:
                begin
                    if (rise)
                    begin
                        s_d.shin = a_in;
                        s_d.cnt = s_q.cnt + 5'h01;
                        // three address bytes complete the header
                        if (s_q.cnt == SFS_ADDR_LAST)
                        begin
                            s_d.cnt = '0;
                            // upper five bits dropped
                            s_d.cmd.valid = 1'b1;
                            s_d.cmd.kind = s_q.kind;
                            s_d.cmd.addr = a_in[SFS_ADDR_W-1:0];
                            s_d.phase = SFS_IGNORE;
                            unique case (s_q.kind)
                                // aligned region holding the address
                                SFS_K_ERASE_4K: s_d.cmd.addr = a_in[18:0] & SFS_MASK_4K;
                                SFS_K_ERASE_32K: s_d.cmd.addr = a_in[18:0] & SFS_MASK_32K;
                                SFS_K_ERASE_64K: s_d.cmd.addr = a_in[18:0] & SFS_MASK_64K;
                                SFS_K_PROGRAM:
                                begin
                                    s_d.page = a_in[18:0] & SFS_MASK_PAGE;
                                    s_d.off = a_in[7:0];
                                    s_d.phase = SFS_PROG;
                                end
                                SFS_K_READ:
                                begin
                                    flush = 1'b1;
                                    s_d.phase = s_q.dummy ? SFS_DUMMY : SFS_READ;
                                end
                                default: s_d.cmd.valid = 1'b0;
                            endcase
                        end
                    end
                end
                SFS_DUMMY:
                begin
                    if (rise)
                    begin
                        s_d.cnt = s_q.cnt + 5'h01;
                        if (s_q.cnt == SFS_BYTE_LAST)
                        begin
                            s_d.phase = SFS_READ;
                        end
                    end
                end
                SFS_READ:
                begin
                    // output changes only on falling edges
                    if (fall)
                    begin
                        step = (s_q.lanes == SFS_LANE_4) ? 4'h4 :
                               (s_q.lanes == SFS_LANE_2) ? 4'h2 : 4'h1;
                        if (s_q.oleft == 4'h0)
                        begin
                            pop = 1'b1;
                            ob = fifo_valid ? fifo_data : 8'h00;
                            s_d.underrun = !fifo_valid;
                            s_d.oleft = 4'h8 - step;
                        end
                        else
                        begin
                            s_d.oleft = s_q.oleft - step;
                        end
                        s_d.osr = ob << step;
                        unique case (s_q.lanes)
                            SFS_LANE_4: s_d.qd_out = ob[7:4];
                            SFS_LANE_2: s_d.qd_out = {2'b00, ob[7:6]};
                            default: s_d.qd_out = {2'b00, ob[7], 1'b0};
                        endcase
                    end
                end
                SFS_PROG:
                begin
                    if (rise)
                    begin
                        s_d.shin = a_in;
                        s_d.cnt = s_q.cnt + 5'h01;
                        if (s_q.cnt == SFS_BYTE_LAST)
                        begin
                            // offset wraps inside the page
                            s_d.cnt = '0;
                            s_d.prog = '{1'b1, s_q.page | {11'h000, s_q.off}, op_in};
                            s_d.off = s_q.off + 8'h01;
                        end
                    end
                end
                default:
                begin
                    s_d.phase = SFS_IGNORE;
                end
            endcase
        end
        // pin direction per phase
        if (s_q.cs_s2)
        begin
            s_d.qd_oe_n = 4'hF;
        end
        else if (s_q.phase == SFS_READ && s_q.lanes == SFS_LANE_4)
        begin
            s_d.qd_oe_n = 4'h0;
        end
        else if (s_q.phase == SFS_READ && s_q.lanes == SFS_LANE_2)
        begin
            s_d.qd_oe_n = 4'hC;
        end
        else
        begin
            s_d.qd_oe_n = 4'hD;
        end
    end

    // state register
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            s_q <= '0;
            s_q.cs_s1 <= 1'b1;
            s_q.cs_s2 <= 1'b1;
            s_q.qd_oe_n <= 4'hF;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign o_quad_data_lines = s_q.qd_out;
    assign o_quad_data_lines_oe_n = s_q.qd_oe_n;
    assign o_cmd = s_q.cmd;
    assign o_prog = s_q.prog;
    assign o_rd_underrun = s_q.underrun;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    // helper: last programmed page within a frame
    logic [10:0] last_page_q;
    logic prog_seen_q;
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst || s_q.cs_s2)
        begin
            prog_seen_q <= 1'b0;
            last_page_q <= '0;
        end
        else if (s_q.prog.valid)
        begin
            prog_seen_q <= 1'b1;
            last_page_q <= s_q.prog.addr[18:8];
        end
    end

    sequence sq_deselected;
        s_q.cs_s2 && $past(s_q.cs_s2);
    endsequence

    sequence sq_quad_selected;
        !s_q.cs_s2 && s_q.phase == SFS_READ && s_q.lanes == SFS_LANE_4;
    endsequence

    chk_float_desel: assert property (sq_deselected |-> s_q.qd_oe_n == 4'hF)
        else $error("data lines driven while deselected");
    chk_single_lane: assert property (s_q.phase != SFS_READ |=> s_q.qd_oe_n[3:2] == 2'b11 && s_q.qd_oe_n[0])
        else $error("extra data line driven outside wide read");
    chk_quad_drive: assert property (sq_quad_selected ##1 !s_q.cs_s2 |-> s_q.qd_oe_n == 4'h0)
        else $error("quad read not driving four lines");
    chk_release_idle: assert property (s_q.cs_s2 |=> s_q.phase == SFS_IDLE && !s_q.cmd.valid)
        else $error("release did not return to idle");
    chk_ignore_hold: assert property (s_q.phase == SFS_IGNORE && !s_q.cs_s2 |=> s_q.phase == SFS_IGNORE)
        else $error("ignore state left without reselect");
    chk_cmd_after_hdr: assert property (s_q.cmd.valid && s_q.cmd.kind != SFS_K_ERASE_CHIP |-> $past(s_q.phase) == SFS_ADDR && $past(s_q.cnt) == SFS_ADDR_LAST)
        else $error("command issued before full address");
    chk_erase_align: assert property (s_q.cmd.valid && s_q.cmd.kind == SFS_K_ERASE_4K |-> s_q.cmd.addr[11:0] == 12'h000)
        else $error("4K erase address not aligned");
    chk_sector_align: assert property (s_q.cmd.valid && s_q.cmd.kind == SFS_K_ERASE_64K |-> s_q.cmd.addr[15:0] == 16'h0000)
        else $error("64K erase address not aligned");
    chk_page_wrap: assert property (s_q.prog.valid && prog_seen_q |-> s_q.prog.addr[18:8] == last_page_q)
        else $error("program left its page");
    chk_rise_count: assert property (rise && !s_q.cs_s2 && s_q.phase == SFS_ADDR && s_q.cnt != SFS_ADDR_LAST |=> s_q.cnt == $past(s_q.cnt) + 5'h01)
        else $error("rising edge not counted in address");
endmodule // sfs_front_end

// ==== hw/sfs_pkg.sv ====
// Notes on behaviour
// - link runs in clock mode 0 or 3
// - sample on rising edge, change on falling
// - all bytes shift most significant bit first
// - releasing select ends the current operation
// - unknown opcode ignored until select re-asserted
// - early release before opcode/address does nothing
// - addressed commands carry exactly three address bytes
// - address bits 23 to 19 are ignored
// - dual read drives two bits per clock
// - quad read drives four bits per clock
// - erase in 4K, 32K, 64K, whole chip
// - erase opcode selects aligned region size
// - eight 64K sectors, 32K halves, 4K blocks
// - page program stays within aligned 256 bytes
// - serial output floats while deselected
package sfs_pkg;

    // ----------------------------------------
    // geometry and field positions
    // ----------------------------------------
    localparam int SFS_ADDR_W = 19;         // used array address bits
    localparam int SFS_BYTE_W = 8;          // bits per byte
    localparam int SFS_SHIFT_W = 24;        // three address bytes
    localparam int SFS_FIFO_DEPTH = 4;      // read data buffer depth
    localparam logic [4:0] SFS_BYTE_LAST = 5'h07;
    localparam logic [4:0] SFS_ADDR_LAST = 5'h17;
    localparam logic [18:0] SFS_MASK_4K = 19'h7_F000;
    localparam logic [18:0] SFS_MASK_32K = 19'h7_8000;
    localparam logic [18:0] SFS_MASK_64K = 19'h7_0000;
    localparam logic [18:0] SFS_MASK_PAGE = 19'h7_FF00;

    // ----------------------------------------
    // opcodes
    // ----------------------------------------
    localparam logic [7:0] SFS_OP_READ = 8'h03;
    localparam logic [7:0] SFS_OP_READ_FAST = 8'h0B;
    localparam logic [7:0] SFS_OP_READ_DUAL = 8'h3B;
    localparam logic [7:0] SFS_OP_READ_QUAD = 8'h6B;
    localparam logic [7:0] SFS_OP_ERASE_4K = 8'h20;
    localparam logic [7:0] SFS_OP_ERASE_32K = 8'h52;
    localparam logic [7:0] SFS_OP_ERASE_64K = 8'hD8;
    localparam logic [7:0] SFS_OP_ERASE_CHIP_A = 8'h60;
    localparam logic [7:0] SFS_OP_ERASE_CHIP_B = 8'hC7;
    localparam logic [7:0] SFS_OP_PROGRAM = 8'h02;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [2:0] {
        SFS_IDLE = 3'b000,
        SFS_OPCODE = 3'b001,
        SFS_ADDR = 3'b010,
        SFS_DUMMY = 3'b011,
        SFS_READ = 3'b100,
        SFS_PROG = 3'b101,
        SFS_IGNORE = 3'b110
    } sfs_phase_t;

    typedef enum logic [1:0] {
        SFS_LANE_1 = 2'b00,
        SFS_LANE_2 = 2'b01,
        SFS_LANE_4 = 2'b10
    } sfs_lane_t;

    typedef enum logic [2:0] {
        SFS_K_NONE = 3'b000,
        SFS_K_READ = 3'b001,
        SFS_K_ERASE_4K = 3'b010,
        SFS_K_ERASE_32K = 3'b011,
        SFS_K_ERASE_64K = 3'b100,
        SFS_K_ERASE_CHIP = 3'b101,
        SFS_K_PROGRAM = 3'b110
    } sfs_kind_t;

    // command issued to the array side
    typedef struct packed {
        logic valid;
        sfs_kind_t kind;
        logic [18:0] addr;
    } sfs_cmd_t;

    // one program byte with its array address
    typedef struct packed {
        logic valid;
        logic [18:0] addr;
        logic [7:0] data;
    } sfs_prog_t;

endpackage
